/* dac_host_consts.svh */
// Constants of the converter host interface
// Contract
// - Interface select pin picks parallel or serial; protocol pin picks shift or 2-wire.
// - Parallel mode queues up to 128 back-to-back instructions.
// - Writes arriving while the queue is full are dropped.
// - Busy stays low while queued instructions execute.
// - Interface wakes fully only on falling write strobe or frame sync.
// - Chain enable low means standalone, high means daisy chain.
// - Frame is 24 bits MSB first: bank, rw, address, register select, data, two spare.
// - Bank bit picks A or B data register; host sends 0 without toggle.
// - Standalone: sync fall restarts count; after 24 bits clock ignored.
// - Standalone accepts free-running or gated serial clock; code rearms the count only on a falling clock with sync high, so gated fails.
// - Daisy chain: bits past the 24th leave on data-out, launched on rising edge.
// - Sync rise after full frame latches word and stops shifting.
// - Sync rise before 24 clocks marks a bad frame, discarded.
// - Read bit set selects register by address and register select.
// - Next frame shifts selected register out; host may send zero word.
// - Readback word: top 10 bits echo address, data in payload positions.
// - Readback bits change on rising clock; first bit ready at frame start.
// - 2-wire slave address is 10101 then the two strap pins.
// - 2-wire side is slave only, never drives clock, up to 400 kHz.
// - Busy stays low while each accepted write is computed.
// - Queue enable pin sampled after reset and after each clear.
`ifndef DAC_HOST_CONSTS_SVH
`define DAC_HOST_CONSTS_SVH
`define FRAME_BITS 24
`define FRAME_CNT_W 5
`define ECHO_BITS 10
`define QUEUE_DEPTH 128
`define QUEUE_PTR_W 7
`define QUEUE_CNT_W 8
`define CLOCK_NS 10
`define COMPUTE_NS 80
`define COMPUTE_CYCLES ((`COMPUTE_NS + `CLOCK_NS - 1) / `CLOCK_NS)
`define COMPUTE_CNT_W 8
`define SLAVE_ADDR_FIXED 5'h15
`define I2C_BITS 8
`define I2C_CNT_W 4
`endif

/* dac_host_pkg.sv */
// Types shared by the converter host interface
`include "dac_host_consts.svh"
package dac_host_pkg;
  // Serial frame layout, first field leaves first
  typedef struct packed {
    logic bank;
    logic read;
    logic [5:0] channel_address_bits;
    logic register_select_hi;
    logic register_select_lo;
    logic [11:0] payload_bits;
    logic [1:0] spare;
  } frame_t;
  // Command handed to the register update logic
  typedef struct packed {
    logic bank;
    logic [5:0] channel;
    logic [1:0] reg_sel;
    logic [11:0] payload_bits;
  } write_cmd_t;
  typedef enum logic [1:0] {MODE_PARALLEL, MODE_SHIFT, MODE_TWO_WIRE} if_mode_t;
  typedef enum logic [1:0] {TW_IDLE, TW_ADDR, TW_ACK, TW_HOLD} tw_state_t;
endpackage

/* dac_serial_host_interface.sv */
// Host write interface: shift port, parallel queue and 2-wire address match
`timescale 1ns/1ps
`include "dac_host_consts.svh"
module dac_serial_host_interface import dac_host_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  output logic sdo,
  input wire logic interface_select_pin,
  input wire logic protocol_select_pin,
  input wire logic chain_enable_pin,
  input wire logic queue_enable_pin,
  input wire logic clr_n,
  input wire logic wr_n,
  input wire frame_t par_word,
  input wire logic slave_addr_strap_hi,
  input wire logic slave_addr_strap_lo,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic i2c_selected,
  input wire logic [11:0] rb_data,
  output logic [7:0] rb_sel,
  output write_cmd_t cmd,
  output logic cmd_valid,
  output logic busy_n,
  output logic interface_awake
);

  // Interface choice from the two select pins
  function automatic if_mode_t decode_mode(input logic ser, input logic proto);
    if (!ser) begin
      decode_mode = MODE_PARALLEL;
    end else if (proto) begin
      decode_mode = MODE_TWO_WIRE;
    end else begin
      decode_mode = MODE_SHIFT;
    end
  endfunction

  function automatic write_cmd_t to_cmd(input frame_t f);
    to_cmd = '{f.bank, f.channel_address_bits,
      {f.register_select_hi, f.register_select_lo}, f.payload_bits};
  endfunction

  // ---------------- Link clock domain ----------------
  frame_t shift_word;
  logic [`FRAME_CNT_W-1:0] bit_cnt;
  logic in_frame;
  logic chain_s1;
  logic chain_s2;
  frame_t out_word;
  frame_t rb_word;

  // Chain strap brought onto the link clock
  always_ff @(negedge sclk) begin
    chain_s1 <= chain_enable_pin;
    chain_s2 <= chain_s1;
  end

  // Input shifter, sampled on falling serial clock
  always_ff @(negedge sclk) begin
    if (sync_n) begin
      in_frame <= 1'b0;
    end else if (!in_frame) begin
      in_frame <= 1'b1;
      bit_cnt <= `FRAME_CNT_W'(1);
      shift_word <= {shift_word[`FRAME_BITS-2:0], din};
    end else if (bit_cnt < `FRAME_CNT_W'(`FRAME_BITS)) begin
      bit_cnt <= bit_cnt + `FRAME_CNT_W'(1);
      shift_word <= {shift_word[`FRAME_BITS-2:0], din};
    end else if (chain_s2) begin
      shift_word <= {shift_word[`FRAME_BITS-2:0], din};
    end
  end

  // Data-out launched on rising serial clock
  // Readback word is taken only while sync is high and the word is settled
  always_ff @(posedge sclk) begin
    if (sync_n) begin
      out_word <= rb_word;
      sdo <= rb_word[`FRAME_BITS-1];
    end else if (chain_s2) begin
      sdo <= shift_word[`FRAME_BITS-1];
    end else begin
      out_word <= {out_word[`FRAME_BITS-2:0], 1'b0};
      sdo <= out_word[`FRAME_BITS-2];
    end
  end

  // ---------------- System clock domain ----------------
  logic sync_s1, sync_s2, sync_s3;
  logic wr_s1, wr_s2, wr_s3;
  logic clr_s1, clr_s2, clr_s3;
  logic ser_s1, ser_s2, pro_s1, pro_s2, qen_s1, qen_s2;
  frame_t par_s1, par_s2;
  logic sync_rise, sync_fall, wr_fall, clr_fall;
  if_mode_t mode;

  // Two-stage synchronisers for pins
  always_ff @(posedge clock) begin
    sync_s1 <= sync_n;
    sync_s2 <= sync_s1;
    sync_s3 <= sync_s2;
    wr_s1 <= wr_n;
    wr_s2 <= wr_s1;
    wr_s3 <= wr_s2;
    clr_s1 <= clr_n;
    clr_s2 <= clr_s1;
    clr_s3 <= clr_s2;
    ser_s1 <= interface_select_pin;
    ser_s2 <= ser_s1;
    pro_s1 <= protocol_select_pin;
    pro_s2 <= pro_s1;
    qen_s1 <= queue_enable_pin;
    qen_s2 <= qen_s1;
    par_s1 <= par_word;
    par_s2 <= par_s1;
  end

  // Edges seen after synchronisation
  assign sync_rise = sync_s2 & ~sync_s3;
  assign sync_fall = ~sync_s2 & sync_s3;
  assign wr_fall = ~wr_s2 & wr_s3;
  assign clr_fall = ~clr_s2 & clr_s3;
  assign mode = decode_mode(ser_s2, pro_s2);

  // Queue enable strap capture
  logic qen_pending;
  logic queue_on;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      qen_pending <= 1'b1;
      queue_on <= 1'b0;
    end else if (clr_fall) begin
      qen_pending <= 1'b1;
    end else if (qen_pending) begin
      qen_pending <= 1'b0;
      queue_on <= qen_s2;
    end
  end

  // Frame latch on rising sync
  logic frame_ok;
  frame_t frame_q;
  logic rb_load;
  // Shift word and count are frozen once sync is high, so this side
  // reads them only after the synchroniser delay
  assign frame_ok = sync_rise && mode == MODE_SHIFT
    && bit_cnt == `FRAME_CNT_W'(`FRAME_BITS);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      frame_q <= '0;
      rb_sel <= '0;
      rb_load <= 1'b0;
      rb_word <= '0;
    end else begin
      rb_load <= 1'b0;
      if (frame_ok) begin
        frame_q <= shift_word;
        rb_word <= '0;
        if (shift_word.read) begin
          rb_sel <= {shift_word.channel_address_bits,
            shift_word.register_select_hi, shift_word.register_select_lo};
          rb_load <= 1'b1;
        end
      end
      if (rb_load) begin
        rb_word <= {frame_q[`FRAME_BITS-1 -: `ECHO_BITS], rb_data, 2'b00};
      end
    end
  end

  // Parallel instruction queue
  frame_t queue_mem [0:`QUEUE_DEPTH-1];
  logic [`QUEUE_PTR_W-1:0] wp, rp;
  logic [`QUEUE_CNT_W-1:0] q_count;
  logic push, pop;
  logic [`COMPUTE_CNT_W-1:0] compute_cnt;
  logic serial_write;

  assign serial_write = frame_ok && !shift_word.read;
  assign push = wr_fall && mode == MODE_PARALLEL
    && (queue_on ? q_count != `QUEUE_CNT_W'(`QUEUE_DEPTH)
                 : q_count == '0 && compute_cnt == '0);
  assign pop = q_count != '0 && compute_cnt == '0 && !serial_write;

  always_ff @(posedge clock) begin
    if (push) begin
      queue_mem[wp] <= par_s2;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || clr_fall) begin
      wp <= '0;
      rp <= '0;
      q_count <= '0;
    end else begin
      if (push) begin
        wp <= wp + `QUEUE_PTR_W'(1);
      end
      if (pop) begin
        rp <= rp + `QUEUE_PTR_W'(1);
      end
      if (push && !pop) begin
        q_count <= q_count + `QUEUE_CNT_W'(1);
      end else if (pop && !push) begin
        q_count <= q_count - `QUEUE_CNT_W'(1);
      end
    end
  end

  // Command issue and value computation time
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmd <= '0;
      cmd_valid <= 1'b0;
      compute_cnt <= '0;
    end else begin
      cmd_valid <= serial_write || pop;
      if (serial_write) begin
        cmd <= to_cmd(shift_word);
        compute_cnt <= `COMPUTE_CNT_W'(`COMPUTE_CYCLES);
      end else if (pop) begin
        cmd <= to_cmd(queue_mem[rp]);
        compute_cnt <= `COMPUTE_CNT_W'(`COMPUTE_CYCLES);
      end else if (compute_cnt != '0) begin
        compute_cnt <= compute_cnt - `COMPUTE_CNT_W'(1);
      end
    end
  end

  // Busy low while work is queued or computing
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy_n <= 1'b1;
    end else begin
      busy_n <= q_count == '0 && compute_cnt == '0
        && !push && !serial_write && !pop;
    end
  end

  // Full power only after a write strobe or sync edge
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      interface_awake <= 1'b0;
    end else if ((mode == MODE_PARALLEL && wr_fall)
        || (mode == MODE_SHIFT && sync_fall)) begin
      interface_awake <= 1'b1;
    end else if (busy_n && sync_s2 && wr_s2 && !i2c_selected) begin
      interface_awake <= 1'b0;
    end
  end

  // ---------------- 2-wire slave address match ----------------
  logic scl_s1, scl_s2, scl_s3, sda_s1, sda_s2, sda_s3;
  logic scl_rise, scl_fall, start_seen, stop_seen;
  tw_state_t tw_state;
  logic [`I2C_CNT_W-1:0] tw_cnt;
  logic [`I2C_BITS-1:0] tw_shift;

  always_ff @(posedge clock) begin
    scl_s1 <= scl_in;
    scl_s2 <= scl_s1;
    scl_s3 <= scl_s2;
    sda_s1 <= sda_in;
    sda_s2 <= sda_s1;
    sda_s3 <= sda_s2;
  end

  // Address straps brought onto the system clock
  logic strap_hi_s1, strap_hi_s2, strap_lo_s1, strap_lo_s2;
  always_ff @(posedge clock) begin
    strap_hi_s1 <= slave_addr_strap_hi;
    strap_hi_s2 <= strap_hi_s1;
    strap_lo_s1 <= slave_addr_strap_lo;
    strap_lo_s2 <= strap_lo_s1;
  end

  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign start_seen = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_seen = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

  // Slave only: data line is the sole driven pin
  always_ff @(posedge clock) begin
    if (!rst_n || mode != MODE_TWO_WIRE) begin
      tw_state <= TW_IDLE;
      tw_cnt <= '0;
      tw_shift <= '0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      i2c_selected <= 1'b0;
    end else if (stop_seen) begin
      tw_state <= TW_IDLE;
      sda_oe <= 1'b0;
      i2c_selected <= 1'b0;
    end else if (start_seen) begin
      tw_state <= TW_ADDR;
      tw_cnt <= '0;
      sda_oe <= 1'b0;
      i2c_selected <= 1'b0;
    end else begin
      case (tw_state)
        TW_IDLE: begin
          sda_oe <= 1'b0;
        end
        TW_ADDR: begin
          if (scl_rise) begin
            tw_shift <= {tw_shift[`I2C_BITS-2:0], sda_s2};
            tw_cnt <= tw_cnt + `I2C_CNT_W'(1);
          end else if (scl_fall && tw_cnt == `I2C_CNT_W'(`I2C_BITS)) begin
            if (tw_shift == {`SLAVE_ADDR_FIXED, strap_hi_s2,
                strap_lo_s2, 1'b0}) begin
              tw_state <= TW_ACK;
              sda_oe <= 1'b1;
              i2c_selected <= 1'b1;
            end else begin
              tw_state <= TW_IDLE;
            end
          end
        end
        TW_ACK: begin
          if (scl_fall) begin
            sda_oe <= 1'b0;
            tw_state <= TW_HOLD;
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

endmodule

/* dac_host_monitor.sv */
// Port checker for the host interface
`timescale 1ns/1ps
module dac_host_monitor import dac_host_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic sync_n,
  input wire logic interface_select_pin,
  input wire logic protocol_select_pin,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire write_cmd_t cmd,
  input wire logic cmd_valid,
  input wire logic busy_n,
  input wire logic interface_awake
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Command pulse and busy window
  a_valid_pulse: assert property (cmd_valid |=> !cmd_valid) else $error("wide pulse");
  a_cmd_held: assert property ($changed(cmd) |-> cmd_valid) else $error("cmd moved");
  a_busy_cmd: assert property (cmd_valid |-> !busy_n[*8]) else $error("busy short");
  a_busy_start: assert property ($fell(busy_n) |-> ##[0:1] cmd_valid) else $error("busy");
  // Wake, mode select and 2-wire answer
  a_wake_sync:
    assert property ($fell(sync_n) && interface_select_pin && !protocol_select_pin
      |-> ##[1:6] interface_awake) else $error("no wake");
  a_sda_low: assert property (!sda_out) else $error("sda driven high");
  a_ack_mode:
    assert property ($rose(sda_oe) |-> interface_select_pin && protocol_select_pin)
      else $error("ack outside 2-wire mode");
  a_ack_hold: assert property ($rose(sda_oe) |=> sda_oe[*8]) else $error("short ack");
  // Main scenarios
  c_cmd: cover property (cmd_valid);
  c_ack: cover property ($rose(sda_oe));
  c_busy: cover property ($fell(busy_n));
endmodule
bind dac_serial_host_interface dac_host_monitor mon (.clock, .rst_n, .sync_n,
  .interface_select_pin, .protocol_select_pin, .sda_out, .sda_oe, .cmd, .cmd_valid,
  .busy_n, .interface_awake);

/* host_serial_model.sv */
// Host serial port model for the shift interface
`timescale 1ns/1ps
module host_serial_model (
  output logic sclk,
  output logic sync_n,
  output logic din,
  input wire logic sdo
);
  logic [47:0] rx = '0;
  // Clock idles high, frame idle
  initial {sclk, sync_n, din} = 3'b110;
  // Clock pulses with frame sync high
  task idle(input int n);
    repeat (n) begin
      #16 sclk = 1'b0;
      #16 sclk = 1'b1;
    end
  endtask
  // Exact clock count, MSB first, data out sampled on falling clock
  // Sync falls mid-high so no rising clock meets it; odd start phase
  // keeps link edges clear of the system clock's rising edges
  task frame(input int n, input logic [47:0] w);
    #9 sync_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      din = w[i];
      #8 sclk = 1'b0;
      rx = {rx[46:0], sdo};
      #16 sclk = 1'b1;
      #8;
    end
    #8 sync_n = 1'b1;
    din = ~din;
    idle(3);
  endtask
endmodule

/* dac_serial_host_interface_tb.sv */
// Self-checking bench for the host write interface
`timescale 1ns/1ps
`define CHECK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module dac_serial_host_interface_tb import dac_host_pkg::*;;
  logic clock = 1'b0, rst_n = 1'b0, wr_n = 1'b1, clr_n = 1'b1, sel = 1'b1, proto = 1'b0;
  logic chain = 1'b0, qen = 1'b1, s_hi = 1'b1, s_lo = 1'b0, scl = 1'b1, m_sda = 1'b1;
  frame_t par_word = '0;
  logic sclk, sync_n, din, sdo, sda_out, sda_oe, i2c_sel, cmd_valid, busy_n, awake;
  logic [7:0] rb_sel;
  logic [11:0] rb_data;
  write_cmd_t cmd;
  int fails = 0, check_count = 0, n_cmd = 0, base;
  // Register stand-in, open-drain line, clock, pulse count
  assign rb_data = {4'h5, rb_sel};
  wire sda_bus = m_sda & ~sda_oe;
  always #5 clock = ~clock;
  always @(posedge clock) if (cmd_valid === 1'b1) n_cmd <= n_cmd + 1;
  dac_serial_host_interface dut (.clock, .rst_n, .sclk, .sync_n, .din, .sdo,
    .interface_select_pin(sel), .protocol_select_pin(proto), .chain_enable_pin(chain),
    .queue_enable_pin(qen), .clr_n, .wr_n, .par_word, .slave_addr_strap_hi(s_hi),
    .slave_addr_strap_lo(s_lo), .scl_in(scl), .sda_in(sda_bus), .sda_out, .sda_oe,
    .i2c_selected(i2c_sel), .rb_data, .rb_sel, .cmd, .cmd_valid, .busy_n,
    .interface_awake(awake));
  host_serial_model host (.sclk, .sync_n, .din, .sdo);
  task cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  // Command expected from a frame
  function automatic write_cmd_t to_cmd(input frame_t f);
    return {f[23], f[21:2]};
  endfunction
  // One serial frame and the count of commands it raised
  task send(input int n, input logic [47:0] w, input int k);
    int b;
    b = n_cmd;
    host.frame(n, w);
    cyc(20);
    if (k >= 0) `CHECK(n_cmd - b, k)
  endtask
  // Parallel write strobe
  task pwrite(input frame_t v);
    par_word <= v;
    wr_n <= 1'b0;
    cyc(1);
    wr_n <= 1'b1;
    cyc(3);
  endtask
  // 2-wire start, address byte and acknowledge clock
  task tw_addr(input logic [7:0] a, input logic ack);
    scl <= 1'b1;
    cyc(60);
    m_sda <= 1'b0;
    cyc(65);
    for (int i = 7; i >= 0; i--) begin
      scl <= 1'b0;
      cyc(60);
      m_sda <= a[i];
      cyc(65);
      scl <= 1'b1;
      cyc(125);
    end
    scl <= 1'b0;
    cyc(20);
    m_sda <= 1'b1;
    cyc(40);
    `CHECK(sda_oe, ack)
    scl <= 1'b1;
    cyc(125);
    `CHECK(i2c_sel, ack)
    scl <= 1'b0;
    cyc(60);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    frame_t w;
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    host.idle(4);
    cyc(8);
    send(26, {24'h9e4bcd, 2'b11}, 1);
    `CHECK(cmd, to_cmd(24'h9e4bcd))
    send(20, 24'h5a5a5, 0);
    `CHECK(cmd, to_cmd(24'h9e4bcd))
    for (int r = 0; r < 4; r++) begin
      w = {2'b00, 6'h2a, r[1:0], 12'hc35, 2'b00};
      send(24, w, 1);
      `CHECK(cmd, to_cmd(w))
    end
    send(24, 24'h6ac000, 0);
    `CHECK(rb_sel, 8'hab)
    send(24, 24'h0, -1);
    `CHECK(host.rx[23:0], {10'h1ab, 12'h5ab, 2'b00})
    chain <= 1'b1;
    host.idle(2);
    send(48, {24'h9e4bcd, 24'h2b0ff0}, 1);
    `CHECK(host.rx[23:0], 24'h9e4bcd)
    `CHECK(cmd, to_cmd(24'h2b0ff0))
    chain <= 1'b0;
    sel <= 1'b0;
    cyc(4);
    send(24, 24'h123456, 0);
    pwrite(24'h0b0123);
    cyc(10);
    `CHECK(cmd, to_cmd(24'h0b0123))
    base = n_cmd;
    for (int i = 0; i < 300; i++) pwrite(i[23:0]);
    for (int k = 0; k < 5000 && busy_n !== 1'b1; k++) cyc(1);
    `CHECK(busy_n, 1'b1)
    `CHECK(n_cmd - base > 199 && n_cmd - base < 300, 1'b1)
    // Queue off after a clear: a write during computation is dropped
    qen <= 1'b0;
    clr_n <= 1'b0;
    cyc(2);
    clr_n <= 1'b1;
    cyc(8);
    base = n_cmd;
    pwrite(24'h0a0111);
    pwrite(24'h0a0222);
    cyc(20);
    `CHECK(n_cmd - base, 1)
    `CHECK(cmd, to_cmd(24'h0a0111))
    sel <= 1'b1;
    cyc(2);
    proto <= 1'b1;
    cyc(4);
    tw_addr(8'hac, 1'b1);
    tw_addr(8'hae, 1'b0);
    tw_addr(8'had, 1'b0);
    close_out;
  end
  // Watchdog
  initial begin
    #400000;
    fails++;
    close_out;
  end
endmodule
